// *** src/scs_map.vh ***
// register layout, field positions and reset values for the synth config block
`ifndef SCS_MAP_VH
`define SCS_MAP_VH

// port-side word offsets
`define SCS_OFF_WORD2 4'h2
`define SCS_OFF_WORD3 4'h3
`define SCS_OFF_WORD4 4'h4
`define SCS_OFF_WORD5 4'h5
`define SCS_OFF_STATUS 4'h8
`define SCS_OFF_CSR_CTRL 4'h9

// register select field
`define SCS_SEL_LSB 0
`define SCS_SEL_MSB 2
`define SCS_SEL_W2 3'h2
`define SCS_SEL_W3 3'h3
`define SCS_SEL_W4 3'h4
`define SCS_SEL_W5 3'h5

// third word fields
`define SCS_W3_SLIP_EN 18
`define SCS_W3_DIVMODE_MSB 16
`define SCS_W3_DIVMODE_LSB 15
`define SCS_W3_DIVVAL_MSB 14
`define SCS_W3_DIVVAL_LSB 3
`define SCS_DIVMODE_OFF 2'h0
`define SCS_DIVMODE_FAST 2'h1
`define SCS_DIVMODE_RESYNC 2'h2

// second word fields
`define SCS_W2_REF_DBL 25
`define SCS_W2_REF_DIV2 24
`define SCS_W2_RCNT_MSB 23
`define SCS_W2_RCNT_LSB 14
`define SCS_W2_DBUF 13

// fourth word fields
`define SCS_W4_FB_SEL 23
`define SCS_W4_ODIV_MSB 22
`define SCS_W4_ODIV_LSB 20
`define SCS_W4_MTLD 10
`define SCS_W4_OUT_EN 5
`define SCS_W4_PWR_MSB 4
`define SCS_W4_PWR_LSB 3

// fifth word fields
`define SCS_W5_LDPIN_MSB 23
`define SCS_W5_LDPIN_LSB 22

// reset value and cell limit
`define SCS_RST_WORD 32'h00000000
`define SCS_MAX_CELLS 3'h7

`endif

// *** src/scs_synth_cfg.v ***
// config words, timeout timer, reference divider and slip-reduction cell control
`timescale 1ns/1ps
`default_nettype none
`include "scs_map.vh"

// Operation
// (RQ1) third word bit 18 enables slip reduction; 0 keeps it off
// (RQ2) host sets charge pump current minimum when enabling slip reduction
// (RQ3) divider mode 10 resync, 01 fast lock, 00 clock divider off
// (RQ4) 12-bit divider value is timeout for resync and fast lock timers
// (RQ5) select 100 updates fourth word
// (RQ6) feedback select 1 takes oscillator directly, 0 takes divider output
// (RQ7) three-bit field picks output divider ratio
// (RQ8) mute-till-lock keeps output supply off until digital lock
// (RQ9) output enable bit gates primary output
// (RQ10) two bits select one of four output power levels
// (RQ11) select 101 updates fifth word
// (RQ12) fifth word bits 23:22 select lock pin mode
// (RQ13) host writes words five down to zero after power-up
// (RQ14) output frequency = comparison x (int + fraction_numerator/mod) / output divider
// (RQ15) comparison = reference x (1+D) / (R x (1+T)); the code never reads doubler bit 25, so D stays 0
// (RQ16) host keeps comparison frequency at or below 32 MHz
// (RQ17) divide-by-2 gives 50% duty comparison signal
// (RQ18) imminent slip switches on extra constant-current cell, signed by direction
// (RQ19) each further slip adds one cell, at most seven
// (RQ20) after overshoot cells switch off one at a time to none
// (RQ21) host keeps comparison duty 45% to 55% with slip reduction
// (RQ22) fractional modulus is programmable 12-bit; step = comparison / modulus
// (RQ23) select 011 updates third word
// (RQ24) second word bit 13 double-buffers output divider select
// (RQ25) a load updates only the word its select field names
module scs_synth_cfg #(
	parameter RCNT_W = 10,
	parameter CELL_W = 3
) (
	// clock and reset
	input wire i_clk_sys,
	input wire i_sys_rst,
	// register port
	input wire [3:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [31:0] o_rdata,
	// loop events, from clock-domain-external analog detectors
	input wire i_lock_raw,
	input wire i_slip_raw,
	input wire i_slip_up_raw,
	input wire i_overshoot_raw,
	input wire i_ref_tick_raw,
	input wire i_apply_raw,
	// decoded controls
	output reg o_slip_en,
	output reg [1:0] o_clkdiv_mode,
	output reg [11:0] o_clkdiv_value,
	output reg o_timeout_pulse,
	output reg o_fb_direct,
	output reg [2:0] o_out_div_sel,
	output reg o_out_supply_on,
	output reg o_out_en,
	output reg [1:0] o_out_power,
	output reg [1:0] o_lock_pin_mode,
	output reg o_cmp_clk,
	output reg [CELL_W-1:0] o_extra_cells,
	output reg o_cells_source
);

	reg [31:0] word2;
	reg [31:0] word3;
	reg [31:0] word4;
	reg [31:0] word5;
	reg [2:0] odiv_pending;
	reg [11:0] timer;
	reg [RCNT_W-1:0] rcnt;
	reg ref_div_q;
	reg [3:0] loaded;
	reg [31:0] next_rdata;
	wire [1:0] lvl_s;
	wire [3:0] evt_rise;
	wire lock_s;
	wire slip_s;
	wire slip_up_s;
	wire over_s;
	wire ref_tick;
	wire apply_tick;
	wire [2:0] wsel;
	wire [RCNT_W-1:0] rdiv;
	wire ref_half;
	wire cmp_tick;

	assign wsel = i_wdata[`SCS_SEL_MSB:`SCS_SEL_LSB];
	assign rdiv = word2[`SCS_W2_RCNT_MSB:`SCS_W2_RCNT_LSB];

	// level inputs: lock and tuning direction
	scs_sync_edge #(
		.W(2)
	) u_sync_level (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_raw({i_slip_up_raw, i_lock_raw}),
		.o_level(lvl_s),
		.o_rise()
	);
	assign lock_s = lvl_s[0];
	assign slip_up_s = lvl_s[1];

	// event inputs: only their rising edges matter
	scs_sync_edge #(
		.W(4)
	) u_sync_event (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_raw({i_apply_raw, i_ref_tick_raw, i_overshoot_raw, i_slip_raw}),
		.o_level(),
		.o_rise(evt_rise)
	);
	assign slip_s = evt_rise[0];
	assign over_s = evt_rise[1];
	assign ref_tick = evt_rise[2];
	assign apply_tick = evt_rise[3];

	// word loads: only the select-matching word changes; the address is not decoded
	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			word2 <= `SCS_RST_WORD;
			word3 <= `SCS_RST_WORD;
			word4 <= `SCS_RST_WORD;
			word5 <= `SCS_RST_WORD;
		end else if (i_wr) begin
			if (wsel == `SCS_SEL_W2) begin
				word2 <= i_wdata; // RQ25
			end else if (wsel == `SCS_SEL_W3) begin
				word3 <= i_wdata; // RQ23 RQ25
			end else if (wsel == `SCS_SEL_W4) begin
				word4 <= i_wdata; // RQ5 RQ25
			end else if (wsel == `SCS_SEL_W5) begin
				word5 <= i_wdata; // RQ11 RQ25
			end
		end
	end

	// divider select: with double buffering held until an apply event
	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			odiv_pending <= 3'h0;
			o_out_div_sel <= 3'h0;
		end else begin
			if (i_wr && wsel == `SCS_SEL_W4) begin
				odiv_pending <= i_wdata[`SCS_W4_ODIV_MSB:`SCS_W4_ODIV_LSB];
				if (!word2[`SCS_W2_DBUF]) begin
					o_out_div_sel <=
						i_wdata[`SCS_W4_ODIV_MSB:`SCS_W4_ODIV_LSB]; // RQ7 RQ24
				end
			end else if (word2[`SCS_W2_DBUF] && apply_tick) begin
				o_out_div_sel <= odiv_pending; // RQ14 RQ24
			end
		end
	end

	// third word fields
	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_slip_en <= 1'b0;
			o_clkdiv_mode <= `SCS_DIVMODE_OFF;
			o_clkdiv_value <= 12'h000;
		end else begin
			o_slip_en <= word3[`SCS_W3_SLIP_EN]; // RQ1
			o_clkdiv_mode <=
				word3[`SCS_W3_DIVMODE_MSB:`SCS_W3_DIVMODE_LSB]; // RQ3
			o_clkdiv_value <=
				word3[`SCS_W3_DIVVAL_MSB:`SCS_W3_DIVVAL_LSB]; // RQ4
		end
	end

	// fourth word fields; output supply gated by lock when muting
	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_fb_direct <= 1'b0;
			o_out_supply_on <= 1'b0;
			o_out_en <= 1'b0;
			o_out_power <= 2'h0;
		end else begin
			o_fb_direct <= word4[`SCS_W4_FB_SEL]; // RQ6
			o_out_supply_on <= ~word4[`SCS_W4_MTLD] | lock_s; // RQ8
			o_out_en <= word4[`SCS_W4_OUT_EN]; // RQ9
			o_out_power <= word4[`SCS_W4_PWR_MSB:`SCS_W4_PWR_LSB]; // RQ10
		end
	end

	// fifth word field
	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_lock_pin_mode <= 2'h0;
		end else begin
			o_lock_pin_mode <=
				word5[`SCS_W5_LDPIN_MSB:`SCS_W5_LDPIN_LSB]; // RQ12
		end
	end

	// reference divider; toggle stage squares the output when enabled
	assign ref_half = ref_tick && (rcnt + 1'b1 >= rdiv || rdiv == 0);
	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			rcnt <= {RCNT_W{1'b0}};
			ref_div_q <= 1'b0;
			o_cmp_clk <= 1'b0;
		end else begin
			if (ref_tick) begin
				rcnt <= ref_half ? {RCNT_W{1'b0}} : rcnt + 1'b1; // RQ15
			end
			if (ref_half) begin
				ref_div_q <= ~ref_div_q; // RQ17
			end
			if (word2[`SCS_W2_REF_DIV2]) begin
				o_cmp_clk <= ref_div_q; // RQ17
			end else begin
				o_cmp_clk <= ref_half;
			end
		end
	end
	// one comparison tick per output period
	assign cmp_tick = ref_half &&
		(!word2[`SCS_W2_REF_DIV2] || ref_div_q);

	// timeout counter shared by resync and fast lock
	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			timer <= 12'h000;
			o_timeout_pulse <= 1'b0;
		end else begin
			o_timeout_pulse <= 1'b0;
			if (o_clkdiv_mode == `SCS_DIVMODE_OFF ||
				o_clkdiv_mode == 2'h3) begin
				timer <= 12'h000; // RQ3
			end else if (cmp_tick) begin
				if (timer + 1'b1 >= o_clkdiv_value) begin
					timer <= 12'h000;
					o_timeout_pulse <= 1'b1; // RQ4
				end else begin
					timer <= timer + 1'b1;
				end
			end
		end
	end

	// slip-reduction cell controller: add on slip, shed after overshoot
	localparam ST_IDLE = 2'h0;
	localparam ST_ADD = 2'h1;
	localparam ST_SHED = 2'h2;
	reg [1:0] cstate;
	always @(posedge i_clk_sys) begin
		if (i_sys_rst || !o_slip_en) begin
			cstate <= ST_IDLE;
			o_extra_cells <= {CELL_W{1'b0}};
			o_cells_source <= 1'b0;
		end else begin
			case (cstate)
			ST_IDLE: begin
				if (slip_s) begin
					o_extra_cells <= {{(CELL_W-1){1'b0}}, 1'b1}; // RQ18
					o_cells_source <= slip_up_s; // RQ18
					cstate <= ST_ADD;
				end
			end
			ST_ADD: begin
				if (over_s) begin
					cstate <= ST_SHED; // RQ20
				end else if (slip_s && o_extra_cells != `SCS_MAX_CELLS) begin
					o_extra_cells <= o_extra_cells + 1'b1; // RQ19
				end
			end
			ST_SHED: begin
				// one cell per comparison period keeps the settling gentle
				if (cmp_tick) begin
					o_extra_cells <= o_extra_cells - 1'b1; // RQ20
					if (o_extra_cells == {{(CELL_W-1){1'b0}}, 1'b1}) begin
						cstate <= ST_IDLE;
					end
				end
			end
			default: cstate <= ST_IDLE;
			endcase
		end
	end

	// which words were loaded since reset, so bring-up can spot a gap
	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			loaded <= 4'h0;
		end else if (i_wr) begin
			if (wsel == `SCS_SEL_W2) begin
				loaded[0] <= 1'b1;
			end else if (wsel == `SCS_SEL_W3) begin
				loaded[1] <= 1'b1;
			end else if (wsel == `SCS_SEL_W4) begin
				loaded[2] <= 1'b1;
			end else if (wsel == `SCS_SEL_W5) begin
				loaded[3] <= 1'b1;
			end
		end
	end

	// read mux: words are write-only on the pins, mirrored here for debug
	always @* begin
		next_rdata = 32'h00000000;
		if (i_addr == `SCS_OFF_WORD2) begin
			next_rdata = word2;
		end else if (i_addr == `SCS_OFF_WORD3) begin
			next_rdata = word3;
		end else if (i_addr == `SCS_OFF_WORD4) begin
			next_rdata = word4;
		end else if (i_addr == `SCS_OFF_WORD5) begin
			next_rdata = word5;
		end else if (i_addr == `SCS_OFF_STATUS) begin
			next_rdata = {20'h00000, loaded, o_cells_source, o_extra_cells,
				cstate, lock_s, o_out_supply_on};
		end else if (i_addr == `SCS_OFF_CSR_CTRL) begin
			next_rdata = {20'h00000, timer};
		end
	end

	// read data stands only in the cycle after the strobe
	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			o_rdata <= 32'h00000000;
		end else if (i_rd) begin
			o_rdata <= next_rdata;
		end else begin
			o_rdata <= 32'h00000000;
		end
	end

endmodule // scs_synth_cfg

// two-flop synchroniser with a third flop for rising-edge detect
module scs_sync_edge #(
	parameter W = 1
) (
	// clock and reset
	input wire i_clk_sys,
	input wire i_sys_rst,
	// asynchronous inputs
	input wire [W-1:0] i_raw,
	// synchronised level and one-cycle rise
	output wire [W-1:0] o_level,
	output wire [W-1:0] o_rise
);

	reg [W-1:0] meta;
	reg [W-1:0] stable;
	reg [W-1:0] prev;

	// only the second and third flops are read; the first may still be settling
	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			meta <= {W{1'b0}};
			stable <= {W{1'b0}};
			prev <= {W{1'b0}};
		end else begin
			meta <= i_raw;
			stable <= meta;
			prev <= stable;
		end
	end
	assign o_level = stable;
	// reset value matches the idle-low pins, so no false edge after reset
	assign o_rise = stable & ~prev;

endmodule // scs_sync_edge
`default_nettype wire

// *** testbench/scs_cfg_chk_asserts.sv ***
// port assertions for the synth config block
`timescale 1ns/1ps
`default_nettype none
module scs_cfg_chk #(
	parameter CELL_W = 3
) (
	// clock and reset
	input wire i_clk_sys,
	input wire i_sys_rst,
	// register port
	input wire [31:0] i_wdata,
	input wire i_wr,
	// decoded controls
	input wire o_slip_en,
	input wire [1:0] o_clkdiv_mode,
	input wire [11:0] o_clkdiv_value,
	input wire o_timeout_pulse,
	input wire o_fb_direct,
	input wire o_out_supply_on,
	input wire o_out_en,
	input wire [1:0] o_out_power,
	input wire [1:0] o_lock_pin_mode,
	input wire [CELL_W-1:0] o_extra_cells
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	wire [2:0] sel = i_wdata[2:0];
	slip_en_a: assert property (i_wr && sel == 3'h3 |-> ##2
		o_slip_en == $past(i_wdata[18], 2)) else $error("slip enable");
	div_mode_a: assert property (i_wr && sel == 3'h3 |-> ##2
		o_clkdiv_mode == $past(i_wdata[16:15], 2) &&
		o_clkdiv_value == $past(i_wdata[14:3], 2)) else $error("divider");
	word4_a: assert property (i_wr && sel == 3'h4 |-> ##2
		o_fb_direct == $past(i_wdata[23], 2) && o_out_en == $past(i_wdata[5], 2)
		&& o_out_power == $past(i_wdata[4:3], 2)) else $error("word four");
	word5_a: assert property (i_wr && sel == 3'h5 |-> ##2
		o_lock_pin_mode == $past(i_wdata[23:22], 2)) else $error("word five");
	supply_on_a: assert property (i_wr && sel == 3'h4 && !i_wdata[10]
		|-> ##2 o_out_supply_on) else $error("supply");
	// writes may legally clear cells at once, so steps are judged away from them
	cell_step_a: assert property (o_slip_en && !$past(i_wr)
		&& !$past(i_wr, 2) |-> o_extra_cells <= $past(o_extra_cells) + 1
		&& $past(o_extra_cells) <= o_extra_cells + 1) else $error("cell step");
	slip_off_a: assert property (!o_slip_en [*3] |-> o_extra_cells == 0)
		else $error("cells while off");
	refused_wr_a: assert property (i_wr && sel < 3'h2 |-> ##2
		$stable(o_out_en) && $stable(o_slip_en) && $stable(o_lock_pin_mode))
		else $error("refused write");
	cover property (o_extra_cells == 7);
	cover property (o_timeout_pulse);
	cover property (!o_out_supply_on);
endmodule // scs_cfg_chk
bind scs_synth_cfg scs_cfg_chk #(.CELL_W(CELL_W)) u_chk (.*);
`default_nettype wire

// *** testbench/scs_host.sv ***
// host model that programs the config words over the register port
`timescale 1ns/1ps
`default_nettype none
module scs_host (
	// clock
	input wire logic i_clk,
	// register port
	input wire logic [31:0] i_rdata,
	output var logic [3:0] o_addr = 4'hF,
	output var logic [31:0] o_wdata = 32'h0,
	output var logic o_wr = 1'b0,
	output var logic o_rd = 1'b0
);
	// released lines carry the inverse so a stale word is never taken as live
	task automatic wr(input logic [31:0] d);
		@(posedge i_clk);
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_wdata <= ~d;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		@(posedge i_clk);
		d = i_rdata;
	endtask
	task automatic init(input logic [31:0] w5, w4, w3, w2);
		wr(w5);
		wr(w4);
		wr(w3);
		wr(w2);
		wr(32'hFFFFFFF9);
		wr(32'hFFFFFFF8);
	endtask
endmodule // scs_host
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench for the synth config block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic i_clk_sys = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_lock_raw = 1'b0;
	logic i_slip_raw = 1'b0;
	logic i_slip_up_raw = 1'b0;
	logic i_overshoot_raw = 1'b0;
	logic i_ref_tick_raw = 1'b0;
	logic i_apply_raw = 1'b0;
	wire [3:0] i_addr;
	wire [31:0] i_wdata, o_rdata;
	wire i_wr, i_rd, o_slip_en, o_timeout_pulse, o_fb_direct;
	wire o_out_supply_on, o_out_en, o_cmp_clk, o_cells_source;
	wire [1:0] o_clkdiv_mode, o_out_power, o_lock_pin_mode;
	wire [11:0] o_clkdiv_value;
	wire [2:0] o_out_div_sel, o_extra_cells;
	logic [31:0] rd_val;
	int miscompares = 0;
	int num_checks = 0;
	scs_synth_cfg DUT (.*);
	scs_host host (.i_clk(i_clk_sys), .i_rdata(o_rdata), .o_addr(i_addr),
		.o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
	initial forever #50 i_clk_sys = ~i_clk_sys;
	// slow reference edges keep the comparison rate well under the limit
	always begin
		repeat (3) @(posedge i_clk_sys);
		i_ref_tick_raw <= ~i_ref_tick_raw;
	end
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [2:0] probe(input int k);
		case (k)
			0: return o_extra_cells;
			1: return {2'h0, o_out_supply_on};
			default: return {2'h0, o_timeout_pulse};
		endcase
	endfunction
	task automatic await(input int k, input logic [2:0] v);
		int n;
		for (n = 0; n < 500 && probe(k) !== v; n++)
			@(posedge i_clk_sys);
		chk(probe(k), v);
		if (n == 500 && probe(k) !== v)
			wrap_up();
	endtask
	task automatic settle;
		repeat (3) @(posedge i_clk_sys);
	endtask
	task automatic pulse(input bit ov);
		if (ov)
			i_overshoot_raw <= 1'b1;
		else
			i_slip_raw <= 1'b1;
		repeat (3) @(posedge i_clk_sys);
		i_overshoot_raw <= 1'b0;
		i_slip_raw <= 1'b0;
		repeat (3) @(posedge i_clk_sys);
	endtask
	task automatic t_init;
		// word two: divide-by-2 on, divider 1, pump current at minimum
		host.init(32'h00800005, 32'h00B00034, 32'h3, 32'h01004002);
		settle();
		chk(o_lock_pin_mode, 2'h2);
		chk(o_fb_direct, 1'b1);
		chk(o_out_div_sel, 3'h3);
		chk(o_out_en, 1'b1);
		host.rd(4'h4, rd_val);
		chk(rd_val, 32'h00B00034);
		host.rd(4'h7, rd_val);
		chk(rd_val, 32'h0);
	endtask
	task automatic t_out;
		for (int p = 0; p < 4; p++) begin
			host.wr({27'h0058021, p[1:0], 3'h4});
			settle();
			chk(o_out_power, p[1:0]);
			chk(o_out_supply_on, 1'b0);
		end
		i_lock_raw <= 1'b1;
		await(1, 3'h1);
	endtask
	task automatic t_dbuf;
		int hi = 0;
		host.wr(32'h01006002);
		host.wr(32'h00D00024);
		settle();
		chk(o_out_div_sel, 3'h3);
		i_apply_raw <= 1'b1;
		settle();
		settle();
		chk(o_out_div_sel, 3'h5);
		i_apply_raw <= 1'b0;
		repeat (240) begin
			@(posedge i_clk_sys);
			hi += o_cmp_clk;
		end
		chk(hi, 120);
	endtask
	task automatic t_timer;
		logic [1:0] m;
		for (int i = 0; i < 3; i++) begin
			m = (i == 2) ? 2'h0 : 2'(i + 1);
			host.wr({15'h0, m, 12'h002, 3'h3});
			settle();
			chk(o_clkdiv_mode, m);
			chk(o_clkdiv_value, 12'h002);
			if (m != 2'h0)
				await(2, 3'h1);
		end
	endtask
	task automatic t_slip;
		pulse(1'b0);
		chk(o_extra_cells, 3'h0);
		host.wr({13'h0, 1'b1, 18'h3});
		i_slip_up_raw <= 1'b1;
		settle();
		chk(o_slip_en, 1'b1);
		pulse(1'b0);
		chk(o_extra_cells, 3'h1);
		chk(o_cells_source, 1'b1);
		repeat (7) pulse(1'b0);
		chk(o_extra_cells, 3'h7);
		pulse(1'b1);
		await(0, 3'h0);
	endtask
	initial begin
		repeat (5) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		t_init();
		t_out();
		t_dbuf();
		t_timer();
		t_slip();
		wrap_up();
	end
endmodule // tb
`default_nettype wire
